//--- hdl/srp_pkg.sv
package srp_pkg;
   // --------------------------------------------------------------
   // Widths and depths
   // --------------------------------------------------------------
   localparam int   SRP_WORD_W    = 36;
   localparam int   SRP_BUF_DEPTH = 2;
   localparam int   SRP_SYNC_LEN  = 3;

   // --------------------------------------------------------------
   // Pin levels
   // --------------------------------------------------------------
   localparam logic SRP_LOAD_ACTIVE = 1'b0;
   localparam logic SRP_DIR_READ    = 1'b1;
   localparam logic SRP_OE_OFF      = 1'b1;

   // --------------------------------------------------------------
   // Reset values
   // --------------------------------------------------------------
   localparam logic SRP_TGL_RST  = 1'b0;
   localparam logic SRP_FLAG_RST = 1'b0;

   // --------------------------------------------------------------
   // Carriers
   // --------------------------------------------------------------
   typedef struct packed {
      logic [SRP_WORD_W-1:0] second;
      logic [SRP_WORD_W-1:0] first;
   } srp_pair_s;

   typedef struct packed {
      logic load_select;
      logic access_dir;
   } srp_cmd_s;
endpackage : srp_pkg

//--- hdl/srp_read_port.sv
`timescale 1ns/1ps
module srp_read_port
   import srp_pkg::*;
#(
   parameter int WORD_W          = srp_pkg::SRP_WORD_W,
   parameter int BUF_DEPTH       = srp_pkg::SRP_BUF_DEPTH,
   parameter bit SINGLE_CLK_MODE = 1'b0
) (
   // Core clock and reset
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   // Read data from the array
   input  wire logic              in_pair_valid,
   input  wire srp_pkg::srp_pair_s in_pair,
   output logic                   in_pair_ready,
   // Access starts seen on the link
   output logic                   read_start,
   output logic                   write_start,
   // Link clocks and control
   input  wire logic              k_clk,
   input  wire logic              out_clk,
   input  wire srp_pkg::srp_cmd_s link_cmd,
   // Read data pins
   output logic [WORD_W-1:0]      q_out,
   output logic                   q_oe_n
);
   import srp_pkg::*;

   localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam int CW = $clog2(BUF_DEPTH + 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(BUF_DEPTH);

   // --------------------------------------------------------------
   // Two-entry buffer in the core domain
   // --------------------------------------------------------------
   srp_pair_s         mem [BUF_DEPTH];
   logic [PW-1:0]     wr_ptr_reg;
   logic [PW-1:0]     rd_ptr_reg;
   logic [CW-1:0]     count_reg;
   logic [CW-1:0]     count_next;
   logic              push;
   logic              pop;
   logic              send_busy_reg;
   logic              req_tgl_reg;
   srp_pair_s         xfer_reg;
   logic              ack_tgl_reg;
   logic [SRP_SYNC_LEN-1:0] ack_sync_reg;

   assign push = in_pair_valid && in_pair_ready;
   assign pop  = (count_reg != '0) && !send_busy_reg;

   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + CW'(1);
      end else if (pop && !push) begin
         count_next = count_reg - CW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_pair;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_ptr_reg    <= '0;
         rd_ptr_reg    <= '0;
         count_reg     <= '0;
         in_pair_ready <= SRP_FLAG_RST;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PW'(BUF_DEPTH - 1)) ? '0
                          : wr_ptr_reg + PW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(BUF_DEPTH - 1)) ? '0
                          : rd_ptr_reg + PW'(1);
         end
         count_reg     <= count_next;
         in_pair_ready <= (count_next < DEPTH_C);
      end
   end

   // --------------------------------------------------------------
   // Word handshake toward the link domain
   // --------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      ack_sync_reg <= {ack_sync_reg[SRP_SYNC_LEN-2:0], ack_tgl_reg};
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         send_busy_reg <= SRP_FLAG_RST;
         req_tgl_reg   <= SRP_TGL_RST;
      end else if (pop) begin
         send_busy_reg <= 1'b1;
         req_tgl_reg   <= ~req_tgl_reg;
      end else if (ack_sync_reg[1] == ack_sync_reg[2]
                   && ack_sync_reg[2] == req_tgl_reg) begin
         send_busy_reg <= 1'b0;
      end
   end

   // Held stable while busy, so the link may sample it
   always_ff @(posedge core_clk) begin
      if (pop) begin
         xfer_reg <= mem[rd_ptr_reg];
      end
   end

   // --------------------------------------------------------------
   // Link domain reset and request crossing
   // --------------------------------------------------------------
   logic [SRP_SYNC_LEN-1:0] lrst_sync_reg;
   logic                    link_rst;
   logic [SRP_SYNC_LEN-1:0] req_sync_reg;
   logic                    taken_tgl_reg;
   logic                    hold_full_reg;
   srp_pair_s               hold_reg;
   srp_pair_s               q_pair_reg;
   logic                    drive_reg;
   logic [1:0]              evt_tgl_reg;
   logic                    load_go;
   logic                    read_go;
   logic                    write_go;
   logic                    new_req;

   always_ff @(posedge k_clk) begin
      lrst_sync_reg <= {lrst_sync_reg[SRP_SYNC_LEN-2:0], sys_rst};
      req_sync_reg  <= {req_sync_reg[SRP_SYNC_LEN-2:0], req_tgl_reg};
   end
   assign link_rst = lrst_sync_reg[2];
   assign new_req  = (req_sync_reg[1] == req_sync_reg[2])
                     && (req_sync_reg[2] != taken_tgl_reg);

   // --------------------------------------------------------------
   // Access decode at the positive input clock edge
   // --------------------------------------------------------------
   assign load_go  = (link_cmd.load_select == SRP_LOAD_ACTIVE);
   assign read_go  = load_go && (link_cmd.access_dir == SRP_DIR_READ);
   assign write_go = load_go && (link_cmd.access_dir != SRP_DIR_READ);

   always_ff @(posedge k_clk) begin
      if (link_rst) begin
         taken_tgl_reg <= SRP_TGL_RST;
         ack_tgl_reg   <= SRP_TGL_RST;
         hold_full_reg <= SRP_FLAG_RST;
      end else if (read_go) begin
         hold_full_reg <= 1'b0;
         ack_tgl_reg   <= taken_tgl_reg;
      end else if (new_req && !hold_full_reg) begin
         hold_full_reg <= 1'b1;
         taken_tgl_reg <= req_sync_reg[2];
      end
   end

   always_ff @(posedge k_clk) begin
      if (new_req && !hold_full_reg && !read_go) begin
         hold_reg <= xfer_reg;
      end
   end

   // Empty holding register reads back as zero
   always_ff @(posedge k_clk) begin
      if (link_rst) begin
         q_pair_reg <= '0;
         drive_reg  <= SRP_FLAG_RST;
      end else begin
         drive_reg <= read_go;
         if (read_go) begin
            q_pair_reg <= hold_full_reg ? hold_reg : '0;
         end
      end
   end

   always_ff @(posedge k_clk) begin
      if (link_rst) begin
         evt_tgl_reg <= {2{SRP_TGL_RST}};
      end else begin
         evt_tgl_reg <= evt_tgl_reg ^ {write_go, read_go};
      end
   end

   // --------------------------------------------------------------
   // Access events back to the core domain
   // --------------------------------------------------------------
   logic [SRP_SYNC_LEN-1:0] evt_sync_reg [2];
   logic [1:0]              evt_seen_reg;
   logic [1:0]              evt_hit;

   for (genvar i = 0; i < 2; i++) begin : g_evt
      always_ff @(posedge core_clk) begin
         evt_sync_reg[i] <= {evt_sync_reg[i][SRP_SYNC_LEN-2:0],
                             evt_tgl_reg[i]};
      end
      assign evt_hit[i] = (evt_sync_reg[i][1] == evt_sync_reg[i][2])
                          && (evt_sync_reg[i][2] != evt_seen_reg[i]);
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            evt_seen_reg[i] <= SRP_TGL_RST;
         end else if (evt_hit[i]) begin
            evt_seen_reg[i] <= evt_sync_reg[i][2];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         read_start  <= SRP_FLAG_RST;
         write_start <= SRP_FLAG_RST;
      end else begin
         read_start  <= evt_hit[0];
         write_start <= evt_hit[1];
      end
   end

   // --------------------------------------------------------------
   // Double data rate launch
   // --------------------------------------------------------------
   logic              launch_clk;
   logic [WORD_W-1:0] q_first_reg;
   logic [WORD_W-1:0] q_second_reg;
   logic [WORD_W-1:0] q_snap_reg;

   assign launch_clk = SINGLE_CLK_MODE ? k_clk : out_clk;

   always_ff @(posedge launch_clk) begin
      if (link_rst) begin
         q_oe_n <= SRP_OE_OFF;
      end else begin
         q_oe_n <= ~drive_reg;
      end
   end

   always_ff @(posedge launch_clk) begin
      q_first_reg <= q_pair_reg.first[WORD_W-1:0];
      q_snap_reg  <= q_pair_reg.second[WORD_W-1:0];
   end

   // Falling edge of the launch clock
   always_ff @(negedge launch_clk) begin
      q_second_reg <= q_snap_reg;
   end

   assign q_out = launch_clk ? q_first_reg : q_second_reg;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   property p_word_width;
      @(posedge core_clk) disable iff (sys_rst)
         (WORD_W == 8) || (WORD_W == 9) || (WORD_W == 18) || (WORD_W == 36);
   endproperty
   a_word_width: assert property (p_word_width)
      else $error("read word width not 8, 9, 18 or 36");

   property p_read_takes_word;
      @(posedge k_clk) disable iff (link_rst)
         (read_go && hold_full_reg) |=>
            (q_pair_reg == $past(hold_reg)) && !hold_full_reg && drive_reg;
   endproperty
   a_read_takes_word: assert property (p_read_takes_word)
      else $error("read did not take the held word");

   property p_write_event;
      @(posedge k_clk) disable iff (link_rst)
         write_go |=> (evt_tgl_reg[1] != $past(evt_tgl_reg[1]))
                      && !drive_reg;
   endproperty
   a_write_event: assert property (p_write_event)
      else $error("write access not started");

   property p_read_event;
      @(posedge k_clk) disable iff (link_rst)
         read_go |=> (evt_tgl_reg[0] != $past(evt_tgl_reg[0]));
   endproperty
   a_read_event: assert property (p_read_event)
      else $error("read access not started at clock edge");

   property p_load_high_idle;
      @(posedge k_clk) disable iff (link_rst)
         !load_go |=> !drive_reg && $stable(q_pair_reg)
                      && $stable(evt_tgl_reg);
   endproperty
   a_load_high_idle: assert property (p_load_high_idle)
      else $error("access started with load select high");

   property p_float_when_idle;
      @(posedge launch_clk) disable iff (link_rst)
         !drive_reg ##1 !drive_reg |-> ##1 q_oe_n;
   endproperty
   a_float_when_idle: assert property (p_float_when_idle)
      else $error("read outputs driven while deselected");

   property p_first_word_launch;
      @(posedge launch_clk) disable iff (link_rst)
         drive_reg |=> !q_oe_n
            && (q_first_reg == $past(q_pair_reg.first[WORD_W-1:0]));
   endproperty
   a_first_word_launch: assert property (p_first_word_launch)
      else $error("first word not launched on positive edge");

   property p_single_clock;
      @(posedge core_clk) disable iff (sys_rst)
         SINGLE_CLK_MODE |-> (launch_clk == k_clk);
   endproperty
   a_single_clock: assert property (p_single_clock)
      else $error("single clock mode not launching from input clock");
endmodule : srp_read_port

//--- sim/srp_ctl_model.sv
`timescale 1ns/1ps
module srp_ctl_model
   import srp_pkg::*;
(
   // Link clock
   input  wire logic              k_clk,
   // Commands to the device
   output srp_pkg::srp_cmd_s      link_cmd
);
   srp_cmd_s cmd_q[$];

   initial link_cmd = '{load_select: 1'b1, access_dir: 1'b0};

   // Change just after the edge, hold for a whole k cycle
   always @(posedge k_clk) begin
      if (cmd_q.size() > 0) begin
         link_cmd <= cmd_q.pop_front();
      end else begin
         // Idle: direction wiggles while load select is high
         link_cmd <= '{1'b1, ~link_cmd.access_dir};
      end
   end

   task automatic send(input srp_cmd_s c);
      cmd_q.push_back(c);
   endtask : send
endmodule : srp_ctl_model

//--- sim/test_sram_read_port_and_access_select.sv
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      comparisons++; \
      if ((a) !== (b)) begin \
         failures++; \
         $display("ERROR %0t: got %h expected %h", $time, a, b); \
      end \
   end
module test_sram_read_port_and_access_select;
   import srp_pkg::*;
   localparam int W = SRP_WORD_W;
   logic          core_clk      = 1'b0;
   logic          k_clk         = 1'b0;
   logic          sys_rst       = 1'b1;
   logic          in_pair_valid = 1'b0;
   srp_pair_s     in_pair       = '0;
   logic          in_pair_ready;
   logic          read_start;
   logic          write_start;
   srp_cmd_s      link_cmd;
   logic [W-1:0]  q_out;
   logic          q_oe_n;
   int            failures, comparisons, cycles, taken;
   int            rd_seen, wr_seen, exp_rd, exp_wr;
   srp_pair_s     exp_q[$];
   bit            ok;

   always #25 core_clk = ~core_clk;
   always #7.5 k_clk = ~k_clk;

   srp_read_port #(.WORD_W(W), .SINGLE_CLK_MODE(1'b1)) i_dut (
      .core_clk(core_clk), .sys_rst(sys_rst),
      .in_pair_valid(in_pair_valid), .in_pair(in_pair),
      .in_pair_ready(in_pair_ready), .read_start(read_start),
      .write_start(write_start), .k_clk(k_clk), .out_clk(k_clk),
      .link_cmd(link_cmd), .q_out(q_out), .q_oe_n(q_oe_n));

   srp_ctl_model i_ctl (.k_clk(k_clk), .link_cmd(link_cmd));

   // --------------------------------------------------------------
   // Event counting and hang guard
   // --------------------------------------------------------------
   always @(posedge core_clk) begin
      cycles++;
      if (read_start === 1'b1) rd_seen++;
      if (write_start === 1'b1) wr_seen++;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end

   task automatic close_out;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out

   task automatic push(output bit acc);
      logic [95:0] r;
      r = {$urandom, $urandom, $urandom};
      acc = 1'b0;
      @(posedge core_clk);
      in_pair_valid <= 1'b1;
      in_pair       <= r[71:0];
      for (int n = 0; n < 40 && !acc; n++) begin
         @(posedge core_clk);
         if (in_pair_ready === 1'b1) acc = 1'b1;
      end
      in_pair_valid <= 1'b0;
      if (acc) exp_q.push_back(r[71:0]);
      repeat (20) @(posedge core_clk);
   endtask : push

   task automatic link_op(input logic ls, input logic dir);
      srp_pair_s e;
      @(posedge k_clk);
      #1;
      i_ctl.send('{ls, dir});
      repeat (2) @(posedge k_clk);
      if (!ls && dir) begin
         exp_rd++;
         e = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
         @(posedge k_clk);
         #1;
         `CHK(q_oe_n, 1'b0)
         `CHK(q_out, e.first[W-1:0])
         @(negedge k_clk);
         #1;
         `CHK(q_out, e.second[W-1:0])
         @(posedge k_clk);
         #1;
         `CHK(q_oe_n, 1'b1)
      end else if (!ls) begin
         exp_wr++;
      end
      repeat (24) @(posedge k_clk);
      `CHK(q_oe_n, 1'b1)
   endtask : link_op

   task automatic events_check(input string name);
      repeat (10) @(posedge core_clk);
      `CHK(rd_seen, exp_rd)
      `CHK(wr_seen, exp_wr)
      $display("test %s done", name);
   endtask : events_check

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      void'($urandom(72620));
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      // Every load select and direction combination, empty buffer
      for (int i = 0; i < 4; i++) begin
         link_op(i[1], i[0]);
      end
      events_check("modes");
      // Fill until refused, then drain in order plus one underrun
      taken = 0;
      ok = 1'b1;
      for (int i = 0; i < 6 && ok; i++) begin
         push(ok);
         if (ok) taken++;
      end
      `CHK(taken >= SRP_BUF_DEPTH, 1'b1)
      for (int i = 0; i <= taken; i++) begin
         link_op(1'b0, 1'b1);
      end
      events_check("fill_drain");
      // Random mix of pushes, reads, writes and ignored cycles
      for (int i = 0; i < 12; i++) begin
         case ($urandom % 3)
            0: push(ok);
            1: link_op(1'b0, 1'b1);
            default: link_op($urandom % 2, 1'b0);
         endcase
      end
      events_check("random_mix");
      close_out();
   end
endmodule : test_sram_read_port_and_access_select
